// ### gate_drv_host.v
// Purpose: host controller driving a gate driver's pwm and reset/enable pins
// Assumes: fault and power-good pins are open drain with pullups, sampled synchronously
// Notes: issues a timed reset pulse on clear_fault_in after a fault, or follows pwm in auto mode
//
// Summary of operation
// - gate works only while reset/enable high; host drives it high to run.
// - host holds reset/enable low reset filter time plus margin after mute time.
// - in auto reset with inverting pwm, host feeds reset/enable the inverse of in_neg_out.
// - in auto reset, a pwm off period shorter than reset filter time plus margin sets pwm_short_out.
`timescale 1ns/1ns
`default_nettype none
`include "gate_ctrl_map.vh"
module gate_drv_host (
  // clock, reset, enable
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // user side
  input wire run_in,
  input wire pwm_in,
  input wire auto_reset_in,
  input wire invert_mode_in,
  input wire clear_fault_in,
  output reg fault_out,
  output reg ready_out,
  output reg busy_out,
  output reg pwm_short_out,
  // device pins
  input wire fault_flag_n_in,
  input wire power_good_in,
  output reg in_pos_out,
  output reg in_neg_out,
  output reg rst_en_out
);
  localparam [3:0] S_OFF = 4'h1;
  localparam [3:0] S_RUN = 4'h2;
  localparam [3:0] S_MUTE = 4'h4;
  localparam [3:0] S_HOLD = 4'h8;
  localparam [`CNT_W-1:0] MUTE_N = `MUTE_CYCLES;
  localparam [`CNT_W-1:0] FILT_N = `FILTER_CYCLES;
  localparam [7:0] DG_N = `DEGLITCH_CYCLES;

  reg [3:0] state_q, state_d;
  reg [`CNT_W-1:0] cnt_q, cnt_d;
  reg [`CNT_W-1:0] off_q;
  reg [1:0] req_q;
  wire flt_lvl;
  wire rdy_lvl;
  wire fault_seen;
  wire pwm_pos;
  wire rst_manual;
  wire pwm_rise;
  reg in_pos_d;
  reg in_neg_d;
  reg rst_en_d;

  // qualified pin levels
  pin_filter #(.STABLE_CYCLES(DG_N)) u_flt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .rst_val_in(1'b0),
    .pin_in(~fault_flag_n_in),
    .level_out(flt_lvl)
  );
  pin_filter #(.STABLE_CYCLES(DG_N)) u_rdy (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .rst_val_in(1'b0),
    .pin_in(power_good_in),
    .level_out(rdy_lvl)
  );
  assign fault_seen = flt_lvl;

  // drive polarity of the pwm pin
  function pwm_sel;
    input inv;
    input p;
    begin
      pwm_sel = inv ? ~p : p;
    end
  endfunction
  assign pwm_pos = pwm_in;
  assign pwm_rise = pwm_pos & ~req_q[0];

  // state is inside the reset pulse
  function in_seq;
    input [3:0] s;
    begin
      in_seq = (s == S_MUTE) || (s == S_HOLD);
    end
  endfunction

  // manual reset sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      S_OFF: begin
        if (run_in) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (!run_in) begin
          state_d = S_OFF;
        end else if (fault_seen && !auto_reset_in && clear_fault_in) begin
          state_d = S_MUTE; // wait out mute time first
          cnt_d = {`CNT_W{1'b0}};
        end
      end
      S_MUTE: begin
        if (cnt_q >= MUTE_N - 1'b1) begin
          state_d = S_HOLD;
          cnt_d = {`CNT_W{1'b0}};
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      S_HOLD: begin
        if (cnt_q >= FILT_N - 1'b1) begin
          state_d = run_in ? S_RUN : S_OFF; // held past filter time
          cnt_d = {`CNT_W{1'b0}};
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = S_OFF;
        cnt_d = {`CNT_W{1'b0}};
      end
    endcase
  end

  // busy follows the next state so it lines up with the enable pin
  assign rst_manual = in_seq(state_d);

  // next pin levels
  always @* begin
    in_pos_d = 1'b0;
    in_neg_d = 1'b0;
    rst_en_d = 1'b0;
    // pwm pins: never both high
    if (invert_mode_in) begin
      in_neg_d = run_in ? pwm_sel(1'b1, pwm_pos) : 1'b1;
    end else begin
      in_pos_d = run_in & pwm_pos;
    end
    // reset/enable pin
    if (state_d == S_OFF || in_seq(state_d)) begin
      rst_en_d = 1'b0; // low disables and resets
    end else if (auto_reset_in) begin
      rst_en_d = pwm_pos; // follow pwm_in uninverted in both modes, the inverse of in_neg_out in inverting mode
    end else begin
      rst_en_d = 1'b1; // high to operate
    end
  end

  // registered outputs

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= S_OFF;
      cnt_q <= {`CNT_W{1'b0}};
      off_q <= {`CNT_W{1'b0}};
      req_q <= 2'b00;
      in_pos_out <= 1'b0;
      in_neg_out <= 1'b0;
      rst_en_out <= 1'b0; // disabled from reset
      fault_out <= 1'b0;
      ready_out <= 1'b0;
      busy_out <= 1'b0;
      pwm_short_out <= 1'b0;
    end else if (ce_in) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      req_q <= {req_q[0], pwm_pos};
      in_pos_out <= in_pos_d;
      in_neg_out <= in_neg_d;
      rst_en_out <= rst_en_d;
      // off period check for auto reset
      if (pwm_pos) begin
        off_q <= {`CNT_W{1'b0}};
      end else if (off_q != {`CNT_W{1'b1}}) begin
        off_q <= off_q + 1'b1;
      end
      if (auto_reset_in && pwm_rise) begin
        pwm_short_out <= (off_q < FILT_N); // off time too short
      end
      fault_out <= fault_seen; // follows the filtered fault pin each cycle
      ready_out <= rdy_lvl; // low in undervoltage
      busy_out <= rst_manual;
    end
  end
  // deglitching is device side; host pulses are held far longer
endmodule // gate_drv_host
`default_nettype wire

// ### gate_ctrl_map.vh
// Purpose: constants for the gate driver host controller
// Assumes: 100 MHz clock, 10 ns period
// Notes: times in ns, counts derived by rounding up
`ifndef GATE_CTRL_MAP_VH
`define GATE_CTRL_MAP_VH
`define CLK_PERIOD_NS 10
`define DEGLITCH_TIME_NS 40
`define FAULT_MUTE_TIME_NS 1000
`define RESET_FILTER_TIME_NS 1000
`define RESET_MARGIN_NS 200
`define MUTE_CYCLES ((`FAULT_MUTE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_CYCLES ((`RESET_FILTER_TIME_NS + `RESET_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEGLITCH_CYCLES ((`DEGLITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 16
`endif

// ### pin_filter.v
// Purpose: qualify a slow input pin (no synchroniser stages)
// Assumes: input synchronous to clk_in
// Notes: level changes only after staying stable for the given cycles
`timescale 1ns/1ns
`default_nettype none
module pin_filter #(
  parameter [7:0] STABLE_CYCLES = 8'h04
) (
  // clock and control
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire rst_val_in,
  // pin
  input wire pin_in,
  output reg level_out
);
  reg [7:0] cnt_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 8'h00;
      level_out <= rst_val_in;
    end else if (ce_in) begin
      if (pin_in == level_out) begin
        cnt_q <= 8'h00;
      end else if (cnt_q >= STABLE_CYCLES - 8'h01) begin
        cnt_q <= 8'h00;
        level_out <= pin_in;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // pin_filter
`default_nettype wire

// ### gate_drv_host_sva.sv
// Purpose: pin checks on the host
// Assumes: ce_in high
// Notes: bound from the bench
`timescale 1ns/1ns
`default_nettype none
module gate_drv_host_sva (
  // watched ports
  input wire logic clk_in, rst_in, run_in, auto_reset_in, invert_mode_in,
  input wire logic busy_out, in_pos_out, in_neg_out, rst_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_excl; !(in_pos_out && in_neg_out); endproperty
  a_excl: assert property (p_excl) else $error("both pwm pins high");
  property p_inv; $past(auto_reset_in && invert_mode_in && run_in && !rst_in)
    |-> rst_en_out != in_neg_out; endproperty
  a_inv: assert property (p_inv) else $error("enable not inverse of pwm");
  property p_run; $past(run_in && !auto_reset_in && !rst_in) && !busy_out |-> rst_en_out;
  endproperty
  a_run: assert property (p_run) else $error("enable low while running");
  property p_hold; busy_out |-> !rst_en_out; endproperty
  a_hold: assert property (p_hold) else $error("enable high in reset pulse");
  property p_len; $fell(busy_out) |-> $past(busy_out, 200); endproperty
  a_len: assert property (p_len) else $error("reset pulse too short");
  c_clear: cover property ($fell(busy_out));
  c_auto: cover property (auto_reset_in && invert_mode_in && !rst_en_out);
  c_run: cover property (in_pos_out);
endmodule // gate_drv_host_sva
`default_nettype wire

// ### gate_drv_model.sv
// Purpose: behavioural gate driver device
// Assumes: pins sampled on host clock
// Notes: open drain lines shown pulled up
`timescale 1ns/1ns
`default_nettype none
module gate_drv_model #(parameter int MUTE = 100, parameter int FIL = 100) (
  input wire logic clk_in, in_pos_in, in_neg_in, rst_en_in, oc_in, uvlo_in,
  output logic fault_flag_n_out, power_good_out, gate_out
);
  int mute_q = 0;
  int fil_q = 0;
  logic flt_q = 0;
  always @(posedge clk_in) begin
    if (oc_in && gate_out) begin
      flt_q <= 1;
      mute_q <= 0;
      fil_q <= 0;
    end else if (flt_q) begin
      mute_q <= mute_q + 1;
      fil_q <= (mute_q >= MUTE && rst_en_in !== 1'b1) ? fil_q + 1 : 0;
      if (fil_q >= FIL) flt_q <= 0;
    end
  end
  assign fault_flag_n_out = !flt_q;
  assign power_good_out = !uvlo_in;
  assign gate_out = in_pos_in && !in_neg_in && rst_en_in === 1'b1 && !flt_q && !uvlo_in;
endmodule // gate_drv_model
`default_nettype wire

// ### gate_drv_host_bench.sv
// Purpose: self-checking bench for the host
// Assumes: device model on the pins
// Notes: inputs driven at falling edge
`timescale 1ns/1ns
`default_nettype none
module gate_drv_host_bench;
  logic clk_in = 0, rst_in = 1, ce_in = 1, run_in = 0, pwm_in = 0, auto_reset_in = 0;
  logic invert_mode_in = 0, clear_fault_in = 0, oc = 0, uvlo = 0;
  wire fault_out, ready_out, busy_out, pwm_short_out, fault_flag_n_in, power_good_in;
  wire in_pos_out, in_neg_out, rst_en_out, gate;
  int err_count = 0, comparisons = 0, seed = 32'h24351be4, i, j;
  always #5 clk_in = ~clk_in;
  gate_drv_host i_dut(.*);
  gate_drv_model i_dev(.clk_in(clk_in), .in_pos_in(in_pos_out | invert_mode_in),
    .in_neg_in(in_neg_out), .rst_en_in(rst_en_out), .oc_in(oc), .uvlo_in(uvlo),
    .fault_flag_n_out(fault_flag_n_in), .power_good_out(power_good_in), .gate_out(gate));
  task chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function logic [1:0] exp_pins(input logic inv, input logic p);
    return inv ? {1'b0, !p} : {p, 1'b0};
  endfunction
  task wait_fault(input logic v);
    for (j = 0; j < 500 && fault_out !== v; j++) @(negedge clk_in);
    chk({1'b0, fault_out}, {1'b0, v});
  endtask
  task summarize;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 0;
    run_in = 1;
    repeat (8) @(negedge clk_in);
    for (i = 0; i < 60; i++) begin
      pwm_in = $random(seed);
      invert_mode_in = $random(seed);
      @(negedge clk_in);
      chk({in_pos_out, in_neg_out}, exp_pins(invert_mode_in, pwm_in));
      chk({1'b0, rst_en_out}, 2'b01);
    end
    invert_mode_in = 0;
    pwm_in = 1;
    repeat (2) @(negedge clk_in);
    oc = 1;
    @(negedge clk_in);
    oc = 0;
    wait_fault(1);
    chk({1'b0, gate}, 2'b00);
    clear_fault_in = 1;
    @(negedge clk_in);
    clear_fault_in = 0;
    chk({1'b0, busy_out}, 2'b01);
    wait_fault(0);
    for (j = 0; j < 300 && busy_out !== 1'b0; j++) @(negedge clk_in);
    @(negedge clk_in);
    chk({gate, rst_en_out}, 2'b11);
    auto_reset_in = 1;
    invert_mode_in = 1;
    repeat (3) @(negedge clk_in);
    oc = 1;
    @(negedge clk_in);
    oc = 0;
    wait_fault(1);
    pwm_in = 0;
    wait_fault(0);
    pwm_in = 1;
    repeat (3) @(negedge clk_in);
    chk({gate, rst_en_out}, 2'b11);
    chk({1'b0, pwm_short_out}, 2'b00);
    pwm_in = 0;
    repeat (10) @(negedge clk_in);
    pwm_in = 1;
    repeat (3) @(negedge clk_in);
    chk({1'b0, pwm_short_out}, 2'b01);
    uvlo = 1;
    repeat (8) @(negedge clk_in);
    chk({ready_out, gate}, 2'b00);
    uvlo = 0;
    repeat (8) @(negedge clk_in);
    chk({ready_out, gate}, 2'b11);
    summarize;
  end
  initial begin
    #100000;
    err_count++;
    summarize;
  end
endmodule // gate_drv_host_bench
bind gate_drv_host gate_drv_host_sva i_sva(.*);
`default_nettype wire
